//--- dv/mrre_host_model.sv
// Host master model: sends request frames and collects reply bytes
`timescale 1ns/1ns
module mrre_host_model
  import mrre_pkg::*;
(
  input  wire logic       ref_clk,
  output logic            rxValid,
  output logic [7:0]      rxByte,
  input  wire logic       txValid,
  input  wire logic [7:0] txByte,
  output logic            txReady
);
  logic [7:0] got[$];
  bit         slow;

  initial begin
    rxValid = 1'b0;
    rxByte  = 8'h00;
    txReady = 1'b1;
    slow    = 1'b0;
  end

  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
    end
    return c;
  endfunction

  // checksum low first unless swap is set, line idle after frame
  task automatic send(input logic [7:0] req[$], input bit swap);
    logic [15:0] c;
    c = crc16(req);
    req.push_back(swap ? c[15:8] : c[7:0]);
    req.push_back(swap ? c[7:0] : c[15:8]);
    got.delete();
    foreach (req[i]) begin
      @(negedge ref_clk);
      rxValid = 1'b1;
      rxByte  = req[i];
    end
    @(negedge ref_clk);
    rxValid = 1'b0;
    rxByte  = ~rxByte;
  endtask

  // Slow mode accepts every other cycle
  always @(negedge ref_clk) begin
    txReady = slow ? ~txReady : 1'b1;
  end

  always @(posedge ref_clk) begin
    if (txValid === 1'b1 && txReady === 1'b1) begin
      got.push_back(txByte);
    end
  end
endmodule

//--- dv/tb.sv
// Testbench for the reply and error logic
`timescale 1ns/1ns
module tb;
  import mrre_pkg::*;
  localparam int         GAP     = 8;
  localparam logic [8:0] OK_ATTR = 9'h168;
  logic        ref_clk = 1'b0;
  logic        reset_n;
  logic        clkEn;
  logic        rxValid;
  logic [7:0]  rxByte;
  logic        txValid;
  logic [7:0]  txByte;
  logic        txReady;
  logic [15:0] regAddr;
  logic [15:0] regRdData;
  logic [15:0] regMax;
  logic [8:0]  attr;
  logic        regDefined, regIsCoil, regReadable, regWritable, regForbidden;
  logic        remoteHere, remoteOther, localLockout, execRefused;
  logic        wrStrobe;
  logic        coilStrobe;
  logic [15:0] wrAddr;
  logic [15:0] wrData;
  int          n_errors = 0;
  int          compares = 0;
  int          nWr = 0;
  int          nCoil = 0;

  assign {regDefined, regIsCoil, regReadable, regWritable, regForbidden,
          remoteHere, remoteOther, localLockout, execRefused} = attr;
  assign regRdData = regAddr ^ 16'h5A3C;

  always #10 ref_clk = ~ref_clk;

  mrre_core #(.GAP_CYCLES_P(GAP)) DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn), .rxValid(rxValid),
    .rxByte(rxByte), .txValid(txValid), .txByte(txByte), .txReady(txReady),
    .regAddr(regAddr), .regRdData(regRdData), .regDefined(regDefined),
    .regIsCoil(regIsCoil), .regReadable(regReadable), .regWritable(regWritable),
    .regForbidden(regForbidden), .regMax(regMax), .remoteHere(remoteHere),
    .remoteOther(remoteOther), .localLockout(localLockout), .execRefused(execRefused),
    .wrStrobe(wrStrobe), .coilStrobe(coilStrobe), .wrAddr(wrAddr), .wrData(wrData)
  );

  mrre_host_model host (
    .ref_clk(ref_clk), .rxValid(rxValid), .rxByte(rxByte),
    .txValid(txValid), .txByte(txByte), .txReady(txReady)
  );

  always @(posedge ref_clk) begin
    if (wrStrobe === 1'b1) nWr++;
    if (coilStrobe === 1'b1) nCoil++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic [7:0] req[$], input bit swap, input logic [7:0] exp[$]);
    logic [15:0] c;
    int          n;
    c = host.crc16(exp);
    exp.push_back(c[7:0]);
    exp.push_back(c[15:8]);
    host.send(req, swap);
    n = 0;
    while (host.got.size() < exp.size() && n < GAP + 400) begin
      @(negedge ref_clk);
      n++;
    end
    repeat (4) @(negedge ref_clk);
    check(16'(host.got.size()), 16'(exp.size()));
    foreach (exp[i]) check(i < host.got.size() ? host.got[i] : 8'hXX, exp[i]);
  endtask

  task automatic test_write_reg();
    attr = OK_ATTR;
    nWr  = 0;
    xfer({8'h00, 8'h06, 8'h01, 8'hF5, 8'h66, 8'h66}, 1'b0,
         {8'h00, 8'h06, 8'h01, 8'hF5, 8'h66, 8'h66});
    check(host.got[6], 8'h32);
    check(16'(nWr), 16'h0001);
    check(wrAddr, 16'h01F5);
    check(wrData, 16'h6666);
  endtask

  task automatic test_coil();
    logic [15:0] w;
    attr  = OK_ATTR ^ 9'h080;
    nCoil = 0;
    xfer({8'h00, 8'h05, 8'h01, 8'h92, 8'hFF, 8'h00}, 1'b0,
         {8'h00, 8'h05, 8'h01, 8'h92, 8'hFF, 8'h00});
    check(host.got[6], 8'h2D);
    check(wrData, COIL_ON);
    attr = OK_ATTR ^ 9'h084;
    xfer({8'h00, 8'h05, 8'h01, 8'h92, 8'h00, 8'h00}, 1'b0,
         {8'h00, 8'h05, 8'h01, 8'h92, 8'h00, 8'h00});
    check(16'(nCoil), 16'h0002);
    w = 16'h0192 ^ 16'h5A3C;
    xfer({8'h00, 8'h01, 8'h01, 8'h92, 8'h00, 8'h01}, 1'b0,
         {8'h00, 8'h01, 8'h02, w[15:8], w[7:0]});
  endtask

  task automatic test_read_regs();
    logic [7:0]  exp[$];
    logic [15:0] w;
    host.slow = 1'b1;
    attr = OK_ATTR ^ 9'h002;
    exp = {8'h00, 8'h03, 8'h06};
    for (int k = 0; k < 3; k++) begin
      w = (16'h01FB + 16'(k)) ^ 16'h5A3C;
      exp.push_back(w[15:8]);
      exp.push_back(w[7:0]);
    end
    xfer({8'h00, 8'h03, 8'h01, 8'hFB, 8'h00, 8'h03}, 1'b0, exp);
    xfer({8'h00, 8'h03, 8'h01, 8'hFB, 8'h00, 8'h00}, 1'b0, {8'h00, 8'h83, ERR_DATA});
    host.slow = 1'b0;
  endtask

  task automatic exc(input logic [7:0] func, input logic [15:0] dat, input logic [8:0] mask,
                     input bit swap, input bit extra, input logic [7:0] code);
    logic [7:0] req[$];
    int         n0;
    attr = OK_ATTR ^ mask;
    req  = {8'h00, func, 8'h01, 8'hF5, dat[15:8], dat[7:0]};
    if (extra) req.push_back(8'h00);
    n0 = nWr + nCoil;
    xfer(req, swap, {8'h00, func | EXC_FLAG, code});
    check(16'(nWr + nCoil - n0), 16'h0000);
  endtask

  task automatic test_errors();
    exc(FUNC_WRITE_REG, 16'h1000, 9'h000, 1'b1, 1'b0, ERR_CRC);
    exc(FUNC_WRITE_REG, 16'h1000, 9'h000, 1'b0, 1'b1, ERR_DATA);
    exc(8'h10, 16'h1000, 9'h000, 1'b0, 1'b0, ERR_FUNC);
    exc(FUNC_READ_REGS, 16'h0001, 9'h100, 1'b0, 1'b0, ERR_ADDR);
    exc(FUNC_READ_REGS, 16'h0001, 9'h080, 1'b0, 1'b0, ERR_FUNC);
    exc(FUNC_WRITE_REG, 16'h1000, 9'h020, 1'b0, 1'b0, ERR_DENIED);
    exc(FUNC_READ_REGS, 16'h0001, 9'h010, 1'b0, 1'b0, ERR_DENIED);
    exc(FUNC_WRITE_REG, 16'h1000, 9'h002, 1'b0, 1'b0, ERR_LOCAL);
    exc(FUNC_WRITE_COIL, COIL_ON, 9'h084, 1'b0, 1'b0, ERR_DENIED);
    exc(FUNC_WRITE_REG, 16'h1000, 9'h008, 1'b0, 1'b0, ERR_DENIED);
    exc(FUNC_WRITE_REG, 16'h1000, 9'h004, 1'b0, 1'b0, ERR_DENIED);
    exc(FUNC_WRITE_REG, 16'hE000, 9'h000, 1'b0, 1'b0, ERR_DATA);
    exc(FUNC_WRITE_REG, 16'h1000, 9'h001, 1'b0, 1'b0, ERR_EXEC);
    exc(FUNC_WRITE_COIL, 16'h1234, 9'h080, 1'b0, 1'b0, ERR_DATA);
    // Frame for another slave address gets no answer and no action
    attr = OK_ATTR;
    nWr  = 0;
    host.send({8'h01, FUNC_WRITE_REG, 8'h01, 8'hF5, 8'h10, 8'h00}, 1'b0);
    repeat (GAP + 30) @(negedge ref_clk);
    check(16'(host.got.size()), 16'h0000);
    check(16'(nWr), 16'h0000);
  endtask

  task automatic finish_test();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    clkEn   = 1'b1;
    regMax  = 16'hCCCC;
    attr    = OK_ATTR;
    repeat (6) @(negedge ref_clk);
    reset_n = 1'b1;
    test_write_reg();
    test_coil();
    test_read_regs();
    test_errors();
    finish_test();
  end

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    finish_test();
  end
endmodule

//--- verilog/mrre_core.sv
// ModBus RTU slave reply builder, request checker and checksum engine
// Behaviour
// - Read coil reply: addr, 0x01, 2, word, CRC
// - Register read: count twice regs, high byte first
// - Exception: addr, function plus 0x80, code, CRC
// - CRC from all ones, shift right, 0xA001
// - Checksum last, low byte before high byte
// - Bad or swapped checksum gives code 0x05
// - Unsupported or wrong function gives code 0x01
// - Undefined register address gives code 0x02
// - Wrong data length gives code 0x03
// - Value above register maximum gives code 0x03
// - Command not executable now gives code 0x04
// - Wrong access direction or forbidden gives 0x07
// - Register write without own remote control gives 0x07
// - Remote entry held elsewhere gives 0x07
// - Writes under local lockout give 0x17
// - Rejected request changes nothing, sends exception
// - Coil read via register read is rejected
// - Exception codes carry protocol faults only
// - Successful single writes are echoed with CRC
// - Coil word 0x0000 false, 0xFF00 true
`timescale 1ns/1ns
module mrre_core
  import mrre_pkg::*;
#(
  parameter int GAP_CYCLES_P = GAP_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        clkEn,
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxByte,
  output logic             txValid,
  output logic [7:0]       txByte,
  input  wire logic        txReady,
  output logic [15:0]      regAddr,
  input  wire logic [15:0] regRdData,
  input  wire logic        regDefined,
  input  wire logic        regIsCoil,
  input  wire logic        regReadable,
  input  wire logic        regWritable,
  input  wire logic        regForbidden,
  input  wire logic [15:0] regMax,
  input  wire logic        remoteHere,
  input  wire logic        remoteOther,
  input  wire logic        localLockout,
  input  wire logic        execRefused,
  output logic             wrStrobe,
  output logic             coilStrobe,
  output logic [15:0]      wrAddr,
  output logic [15:0]      wrData
);

  mrre_state_t      state_q;
  logic [7:0]       frameBuf_q [0:7];
  logic [7:0]       rxCnt_q;
  logic [15:0]      crcRx_q;
  logic [15:0]      crcTx_q;
  logic [GAP_W-1:0] gapCnt_q;
  logic             gapHit;
  logic [7:0]       txIdx_q;
  logic [7:0]       txLen_q;
  logic [7:0]       txLen_d;
  logic             isExc_q;
  logic [7:0]       errCode_q;
  logic [7:0]       errCode_d;
  logic             dropFrame;
  logic             txByte_q;
  logic [7:0]       txData_q;
  logic [7:0]       nextByte;
  logic             loadByte;
  logic [7:0]       dataIdx;
  logic [7:0]       functionCodeByte;
  logic [15:0]      startReg;
  logic [15:0]      dataWord;
  logic             isRead;
  logic             isWrite;
  logic             wrStrobe_q;
  logic             coilStrobe_q;

  // Checksum step for one byte
  function automatic logic [15:0] crcStep(input logic [15:0] crcIn, input logic [7:0] data);
    logic [15:0] c;
    c = crcIn ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  assign functionCodeByte = frameBuf_q[1];
  assign startReg         = {frameBuf_q[2], frameBuf_q[3]};
  assign dataWord         = {frameBuf_q[4], frameBuf_q[5]};
  assign isRead  = (functionCodeByte == FUNC_READ_COIL) || (functionCodeByte == FUNC_READ_REGS);
  assign isWrite = (functionCodeByte == FUNC_WRITE_COIL) || (functionCodeByte == FUNC_WRITE_REG);
  assign dataIdx = (txIdx_q >= FIRST_DATA) ? (txIdx_q - FIRST_DATA) : 8'h00;
  assign regAddr = startReg + {8'h00, 1'b0, dataIdx[7:1]};
  assign wrAddr  = startReg;
  assign wrData  = dataWord;
  assign txValid = txByte_q;
  assign txByte  = txData_q;
  assign wrStrobe   = wrStrobe_q;
  assign coilStrobe = coilStrobe_q;
  assign gapHit = (rxCnt_q != 8'h00) && (gapCnt_q == GAP_W'(GAP_CYCLES_P - 1));
  assign dropFrame = (rxCnt_q < MIN_LEN) || (frameBuf_q[0] != SLAVE_ADDR);

  // Request checking in priority order
  always_comb begin
    errCode_d = ERR_NONE;
    if (crcRx_q != 16'h0000) begin
      errCode_d = ERR_CRC;
    end else if (rxCnt_q != REQ_LEN) begin
      errCode_d = ERR_DATA;
    end else if (!isRead && !isWrite) begin
      errCode_d = ERR_FUNC;
    end else if (!regDefined) begin
      errCode_d = ERR_ADDR;
    end else if (regIsCoil != ((functionCodeByte == FUNC_READ_COIL) ||
                               (functionCodeByte == FUNC_WRITE_COIL))) begin
      errCode_d = ERR_FUNC;
    end else if (regForbidden || (isRead && !regReadable) || (isWrite && !regWritable)) begin
      errCode_d = ERR_DENIED;
    end else if (isWrite && localLockout) begin
      errCode_d = ERR_LOCAL;
    end else if ((functionCodeByte == FUNC_READ_COIL) && (dataWord != 16'h0001)) begin
      errCode_d = ERR_DATA;
    end else if ((functionCodeByte == FUNC_READ_REGS) &&
                 ((dataWord == 16'h0000) || (dataWord > MAX_READ_REGS))) begin
      errCode_d = ERR_DATA;
    end else if ((functionCodeByte == FUNC_WRITE_COIL) &&
                 (dataWord != COIL_ON) && (dataWord != COIL_OFF)) begin
      errCode_d = ERR_DATA;
    end else if ((functionCodeByte == FUNC_WRITE_COIL) && (dataWord == COIL_ON) &&
                 remoteOther) begin
      errCode_d = ERR_DENIED;
    end else if ((functionCodeByte == FUNC_WRITE_REG) && (!remoteHere || remoteOther)) begin
      errCode_d = ERR_DENIED;
    end else if ((functionCodeByte == FUNC_WRITE_REG) && (dataWord > regMax)) begin
      errCode_d = ERR_DATA;
    end else if (execRefused) begin
      errCode_d = ERR_EXEC;
    end
  end

  // Reply length
  always_comb begin
    if (errCode_d != ERR_NONE) begin
      txLen_d = EXC_LEN;
    end else if (functionCodeByte == FUNC_READ_COIL) begin
      txLen_d = COIL_LEN;
    end else if (functionCodeByte == FUNC_READ_REGS) begin
      txLen_d = READ_BASE_LEN + {frameBuf_q[5][6:0], 1'b0};
    end else begin
      txLen_d = REQ_LEN;
    end
  end

  // Reply byte at the current index
  always_comb begin
    nextByte = frameBuf_q[0];
    if (txIdx_q == txLen_q - 8'h02) begin
      nextByte = crcTx_q[7:0];
    end else if (txIdx_q == txLen_q - 8'h01) begin
      nextByte = crcTx_q[15:8];
    end else if (txIdx_q == 8'h01) begin
      nextByte = isExc_q ? (functionCodeByte | EXC_FLAG) : functionCodeByte;
    end else if (txIdx_q == 8'h02) begin
      if (isExc_q) begin
        nextByte = errCode_q;
      end else if (functionCodeByte == FUNC_READ_COIL) begin
        nextByte = COIL_BYTES;
      end else if (functionCodeByte == FUNC_READ_REGS) begin
        nextByte = {frameBuf_q[5][6:0], 1'b0};
      end else begin
        nextByte = frameBuf_q[2];
      end
    end else if (txIdx_q != 8'h00) begin
      if (isRead) begin
        nextByte = dataIdx[0] ? regRdData[7:0] : regRdData[15:8];
      end else begin
        nextByte = frameBuf_q[txIdx_q[2:0]];
      end
    end
  end

  assign loadByte = (state_q == ST_SEND) && (!txByte_q || txReady);

  // Sequencing
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_RECV;
    end else if (clkEn) begin
      case (state_q)
        ST_RECV: begin
          if (gapHit && !rxValid) begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          state_q <= dropFrame ? ST_RECV : ST_SEND;
        end
        ST_SEND: begin
          if (loadByte && (txIdx_q == txLen_q)) begin
            state_q <= ST_RECV;
          end
        end
        default: begin
          state_q <= ST_RECV;
        end
      endcase
    end
  end

  // Receive buffer, gap counter and checksum
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rxCnt_q  <= 8'h00;
      crcRx_q  <= CRC_INIT;
      gapCnt_q <= '0;
      for (int i = 0; i < 8; i++) begin
        frameBuf_q[i] <= 8'h00;
      end
    end else if (clkEn) begin
      if (state_q == ST_CHECK) begin
        rxCnt_q <= 8'h00;
        crcRx_q <= CRC_INIT;
      end else if ((state_q == ST_RECV) && rxValid) begin
        gapCnt_q <= '0;
        if (rxCnt_q != 8'hFF) begin
          rxCnt_q <= rxCnt_q + 8'h01;
        end
        if (rxCnt_q < BUF_DEPTH) begin
          frameBuf_q[rxCnt_q[2:0]] <= rxByte;
        end
        crcRx_q <= crcStep(crcRx_q, rxByte);
      end else if ((state_q == ST_RECV) && (rxCnt_q != 8'h00) && !gapHit) begin
        gapCnt_q <= gapCnt_q + GAP_W'(1);
      end else begin
        gapCnt_q <= '0;
      end
    end
  end

  // Verdict and side effects
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      isExc_q      <= 1'b0;
      errCode_q    <= ERR_NONE;
      txLen_q      <= 8'h00;
      wrStrobe_q   <= 1'b0;
      coilStrobe_q <= 1'b0;
    end else if (clkEn) begin
      wrStrobe_q   <= 1'b0;
      coilStrobe_q <= 1'b0;
      if ((state_q == ST_CHECK) && !dropFrame) begin
        isExc_q   <= (errCode_d != ERR_NONE);
        errCode_q <= errCode_d;
        txLen_q   <= txLen_d;
        wrStrobe_q   <= (errCode_d == ERR_NONE) && (functionCodeByte == FUNC_WRITE_REG);
        coilStrobe_q <= (errCode_d == ERR_NONE) && (functionCodeByte == FUNC_WRITE_COIL);
      end
    end
  end

  // Transmit stream and reply checksum
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      txIdx_q  <= 8'h00;
      txByte_q <= 1'b0;
      txData_q <= 8'h00;
      crcTx_q  <= CRC_INIT;
    end else if (clkEn) begin
      if (state_q == ST_CHECK) begin
        txIdx_q <= 8'h00;
        crcTx_q <= CRC_INIT;
      end else if (loadByte) begin
        if (txIdx_q == txLen_q) begin
          txByte_q <= 1'b0;
        end else begin
          txByte_q <= 1'b1;
          txData_q <= nextByte;
          txIdx_q  <= txIdx_q + 8'h01;
          if (txIdx_q < txLen_q - 8'h02) begin
            crcTx_q <= crcStep(crcTx_q, nextByte);
          end
        end
      end
    end
  end

  // no alarm input reaches the error codes

  default clocking cb @(posedge ref_clk iff clkEn); endclocking
  default disable iff (!reset_n);

  property p_crcErr;
    (state_q == ST_CHECK) && !dropFrame && (crcRx_q != 16'h0000)
      |=> isExc_q && (errCode_q == ERR_CRC);
  endproperty
  a_crcErr: assert property (p_crcErr) else $error("bad checksum not answered with 0x05");

  property p_excFc;
    txByte_q && isExc_q && (txIdx_q == 8'h02) |-> txData_q == (functionCodeByte | EXC_FLAG);
  endproperty
  a_excFc: assert property (p_excFc) else $error("exception function byte wrong");

  property p_coilCount;
    txByte_q && !isExc_q && (functionCodeByte == FUNC_READ_COIL) && (txIdx_q == 8'h03)
      |-> txData_q == COIL_BYTES;
  endproperty
  a_coilCount: assert property (p_coilCount) else $error("coil byte count wrong");

  property p_regCount;
    txByte_q && !isExc_q && (functionCodeByte == FUNC_READ_REGS) && (txIdx_q == 8'h03)
      |-> txData_q == {frameBuf_q[5][6:0], 1'b0};
  endproperty
  a_regCount: assert property (p_regCount) else $error("register byte count wrong");

  property p_crcLow;
    txByte_q && (txIdx_q == txLen_q - 8'h01) |-> txData_q == crcTx_q[7:0];
  endproperty
  a_crcLow: assert property (p_crcLow) else $error("checksum low byte not first");

  property p_noActOnErr;
    (wrStrobe_q || coilStrobe_q) |-> !isExc_q && (errCode_q == ERR_NONE);
  endproperty
  a_noActOnErr: assert property (p_noActOnErr) else $error("action on rejected request");

  property p_local;
    (state_q == ST_CHECK) && localLockout |=> !wrStrobe_q && !coilStrobe_q;
  endproperty
  a_local: assert property (p_local) else $error("write taken under lockout");

  property p_remote;
    (state_q == ST_CHECK) && !remoteHere |=> !wrStrobe_q;
  endproperty
  a_remote: assert property (p_remote) else $error("register write without remote");

  property p_coilWord;
    coilStrobe_q |-> (dataWord == COIL_ON) || (dataWord == COIL_OFF);
  endproperty
  a_coilWord: assert property (p_coilWord) else $error("coil word not 0x0000 or 0xFF00");

  property p_gapEnd;
    (state_q == ST_RECV) ##1 (state_q == ST_CHECK) |-> $past(gapHit);
  endproperty
  a_gapEnd: assert property (p_gapEnd) else $error("frame ended without idle gap");

  c_exception: cover property (txByte_q && isExc_q && (txIdx_q == txLen_q));
  c_regWrite:  cover property (wrStrobe_q);
  c_coilWrite: cover property (coilStrobe_q);
  c_regRead:   cover property (txByte_q && (functionCodeByte == FUNC_READ_REGS) && !isExc_q);

endmodule

//--- verilog/mrre_pkg.sv
// Constants and types for the ModBus RTU reply and error logic
package mrre_pkg;

  localparam logic [7:0]  SLAVE_ADDR    = 8'h00;
  localparam logic [7:0]  FUNC_READ_COIL  = 8'h01;
  localparam logic [7:0]  FUNC_READ_REGS  = 8'h03;
  localparam logic [7:0]  FUNC_WRITE_COIL = 8'h05;
  localparam logic [7:0]  FUNC_WRITE_REG  = 8'h06;
  localparam logic [7:0]  EXC_FLAG      = 8'h80;

  localparam logic [7:0]  ERR_NONE      = 8'h00;
  localparam logic [7:0]  ERR_FUNC      = 8'h01;
  localparam logic [7:0]  ERR_ADDR      = 8'h02;
  localparam logic [7:0]  ERR_DATA      = 8'h03;
  localparam logic [7:0]  ERR_EXEC      = 8'h04;
  localparam logic [7:0]  ERR_CRC       = 8'h05;
  localparam logic [7:0]  ERR_DENIED    = 8'h07;
  localparam logic [7:0]  ERR_LOCAL     = 8'h17;

  localparam logic [15:0] CRC_INIT      = 16'hFFFF;
  localparam logic [15:0] CRC_POLY      = 16'hA001;
  localparam logic [15:0] COIL_ON       = 16'hFF00;
  localparam logic [15:0] COIL_OFF      = 16'h0000;
  localparam logic [7:0]  COIL_BYTES    = 8'h02;
  localparam logic [15:0] MAX_READ_REGS = 16'h007D;

  localparam logic [7:0]  REQ_LEN       = 8'h08;
  localparam logic [7:0]  MIN_LEN       = 8'h04;
  localparam logic [7:0]  BUF_DEPTH     = 8'h08;
  localparam logic [7:0]  EXC_LEN       = 8'h05;
  localparam logic [7:0]  COIL_LEN      = 8'h07;
  localparam logic [7:0]  READ_BASE_LEN = 8'h05;
  localparam logic [7:0]  FIRST_DATA    = 8'h03;

  // Idle gap of 3.5 characters of 11 bits at 9600 baud
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          GAP_TIME_NS   = 4010417;
  localparam int          GAP_CYCLES    = (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          GAP_W         = 24;

  typedef enum logic [2:0] {
    ST_RECV  = 3'b001,
    ST_CHECK = 3'b010,
    ST_SEND  = 3'b100
  } mrre_state_t;

endpackage
